// ==== tdc_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none

module tdc_sync #(
  parameter int           WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage, to keep metastability contained.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : tdc_sync

`default_nettype wire

// ==== tdc_core.sv ====
// Package and top module of the tracking converter digital control.
//
// Overview of operation
// - Large angle error raises the self-test flag.
// - Over-velocity raises the self-test flag.
// - Loop failure to null raises the flag.
// - Signal or reference loss raises the flag.
// - One input selects short or long word.
// - Resolution select sampled at busy pulse end.
// - Hold freezes outputs, counter keeps tracking.
// - Hold may last forever; tracking continues.
// - Counter changes 50 ns after busy starts.
// - Angle outputs can go high-impedance.
// - Byte enables gate bytes; unused bits zero.
// - Latch holds on hold low, passes high.
// - Busy locks latch; hold waits for end.
// - Busy pulse lasts 0.8 to 3.0 us.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

package tdc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int BUSY_MIN_NS   = 800;
  localparam int BUSY_MAX_NS   = 3000;
  localparam int DATA_DELAY_NS = 50;

  // The busy pulse uses the shortest legal width to keep update throughput high.
  localparam int BUSY_CYC  = (BUSY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_LIM  = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int DELAY_CYC = (DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD  = CNT_W'(BUSY_CYC - DELAY_CYC - 1);

  localparam int ANGLE_W = 16;
  localparam int BYTE_W  = 8;
  localparam int PAD_W   = 2;
  localparam logic [ANGLE_W-1:0] STEP_LONG  = 16'h0001;
  localparam logic [ANGLE_W-1:0] STEP_SHORT = 16'h0004;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_ANGLE    = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_LATCHED  = 12'h014;

  localparam int CTRL_TRACK_BIT = 0;
  localparam logic CTRL_TRACK_RST = 1'b1;

  localparam int IRQ_W          = 3;
  localparam int IRQ_SELF_TEST  = 0;
  localparam int IRQ_UPDATE     = 1;
  localparam int IRQ_RES_CHANGE = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  localparam int ST_SELF_TEST = 0;
  localparam int ST_BUSY      = 1;
  localparam int ST_SHORT     = 2;
  localparam int ST_LATCH_OPEN = 3;
  localparam int ST_FAULT_LSB = 4;

  localparam int SYNC_W = 11;
  // Byte enables and hold request idle high, so they reset high.
  localparam logic [SYNC_W-1:0] SYNC_INIT = 11'h007;

  typedef struct packed {
    logic error_large;
    logic over_velocity;
    logic loop_fail;
    logic signal_loss;
    logic reference_loss;
  } tdc_fault_s;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              oe;
  } tdc_byte_s;

  typedef enum logic [1:0] {
    BUSY_IDLE,
    BUSY_DELAY,
    BUSY_HOLD
  } tdc_busy_e;

endpackage : tdc_pkg

module tdc_core (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tdc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire tdc_pkg::tdc_fault_s         fault_in,
  input  wire logic                        vco_up,
  input  wire logic                        vco_down,
  input  wire logic                        short_word_select,
  input  wire logic                        hold_request_n,
  input  wire logic                        upper_byte_enable_n,
  input  wire logic                        lower_byte_enable_n,
  output var  logic                        update_busy_pulse,
  output var  logic                        self_test_flag,
  output var  tdc_pkg::tdc_byte_s          upper_byte,
  output var  tdc_pkg::tdc_byte_s          lower_byte,
  output var  logic                        irq
);

  logic [tdc_pkg::SYNC_W-1:0] sync_s;

  tdc_sync #(
    .WIDTH (tdc_pkg::SYNC_W),
    .INIT  (tdc_pkg::SYNC_INIT)
  ) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({fault_in, vco_up, vco_down, short_word_select,
                hold_request_n, upper_byte_enable_n, lower_byte_enable_n}),
    .sync_out (sync_s)
  );

  wire tdc_pkg::tdc_fault_s faults_s = sync_s[10:6];
  wire logic up_s      = sync_s[5];
  wire logic dn_s      = sync_s[4];
  wire logic short_s   = sync_s[3];
  wire logic hold_n_s  = sync_s[2];
  wire logic ube_n_s   = sync_s[1];
  wire logic lbe_n_s   = sync_s[0];

  // Registers.
  logic                             up_prev_reg;
  logic                             dn_prev_reg;
  logic                             pend_up_reg;
  logic                             pend_dn_reg;
  logic                             dir_up_reg;
  logic                             open_at_start_reg;
  tdc_pkg::tdc_busy_e               state_reg;
  tdc_pkg::tdc_busy_e               state_next;
  logic [tdc_pkg::CNT_W-1:0]        cnt_reg;
  logic [tdc_pkg::CNT_W-1:0]        cnt_next;
  logic                             busy_reg;
  logic                             busy_prev_reg;
  logic                             short_reg;
  logic [tdc_pkg::ANGLE_W-1:0]      angle_reg;
  logic [tdc_pkg::ANGLE_W-1:0]      latched_reg;
  logic                             track_en_reg;
  logic [tdc_pkg::IRQ_W-1:0]        irq_stat_reg;
  logic [tdc_pkg::IRQ_W-1:0]        irq_stat_next;
  logic [tdc_pkg::IRQ_W-1:0]        irq_mask_reg;

  // Counter update requests from the VCO, caught on rising edges.
  wire logic up_edge  = up_s & ~up_prev_reg;
  wire logic dn_edge  = dn_s & ~dn_prev_reg;
  wire logic req_up   = pend_up_reg | up_edge;
  wire logic req_dn   = pend_dn_reg | dn_edge;
  wire logic idle     = (state_reg == tdc_pkg::BUSY_IDLE);
  wire logic start    = idle & track_en_reg & (req_up | req_dn);
  wire logic take_up  = start & req_up;
  wire logic take_dn  = start & ~req_up & req_dn;
  // An edge landing in the cycle its pending flag is consumed is kept.
  wire logic pend_up_next = (req_up & ~take_up) | (take_up & pend_up_reg & up_edge);
  wire logic pend_dn_next = (req_dn & ~take_dn) | (take_dn & pend_dn_reg & dn_edge);

  wire logic delay_done = (state_reg == tdc_pkg::BUSY_DELAY) && (cnt_reg == '0);
  wire logic hold_done  = (state_reg == tdc_pkg::BUSY_HOLD) && (cnt_reg == '0);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      tdc_pkg::BUSY_IDLE: begin
        if (start) begin
          state_next = tdc_pkg::BUSY_DELAY;
          cnt_next   = tdc_pkg::DELAY_LOAD;
        end
      end
      tdc_pkg::BUSY_DELAY: begin
        if (delay_done) begin
          state_next = tdc_pkg::BUSY_HOLD;
          cnt_next   = tdc_pkg::HOLD_LOAD;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      tdc_pkg::BUSY_HOLD: begin
        if (hold_done) begin
          state_next = tdc_pkg::BUSY_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = tdc_pkg::BUSY_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  wire logic busy_next = (state_next != tdc_pkg::BUSY_IDLE);
  wire logic busy_fall = busy_prev_reg & ~busy_reg;

  // Step size follows the resolution in force, so velocity scaling moves with it.
  wire logic [tdc_pkg::ANGLE_W-1:0] step = short_reg ? tdc_pkg::STEP_SHORT
                                                     : tdc_pkg::STEP_LONG;
  wire logic [tdc_pkg::ANGLE_W-1:0] angle_step =
    dir_up_reg ? angle_reg + step : angle_reg - step;

  // Unused low bits read as zero in short-word mode.
  wire logic [tdc_pkg::ANGLE_W-1:0] angle_view = short_reg
    ? {angle_reg[tdc_pkg::ANGLE_W-1:tdc_pkg::PAD_W], {tdc_pkg::PAD_W{1'b0}}}
    : angle_reg;

  // A hold raised during busy still lets the fresh value in as the pulse ends.
  // A hold already in force when the pulse began keeps the latch shut throughout.
  wire logic latch_open = ~busy_reg & (hold_n_s | (busy_fall & open_at_start_reg));

  wire logic fault_any = |faults_s;
  wire logic self_test_rise = fault_any & ~self_test_flag;
  wire logic res_change = busy_fall & (short_s != short_reg);

  // APB decode; writes land on the edge that completes the transfer.
  wire logic acc_first = psel & penable & ~pready;
  wire logic acc_done  = psel & penable & pready;
  wire logic wr_en     = acc_done & pwrite;
  wire logic sel_ctrl  = (paddr == tdc_pkg::ADDR_CTRL);
  wire logic sel_stat  = (paddr == tdc_pkg::ADDR_STATUS);
  wire logic sel_istat = (paddr == tdc_pkg::ADDR_IRQ_STAT);
  wire logic sel_imask = (paddr == tdc_pkg::ADDR_IRQ_MASK);
  wire logic sel_angle = (paddr == tdc_pkg::ADDR_ANGLE);
  wire logic sel_latch = (paddr == tdc_pkg::ADDR_LATCHED);
  wire logic hit = sel_ctrl | sel_stat | sel_istat | sel_imask | sel_angle | sel_latch;

  wire logic [31:0] status_word = {
    23'h000000,
    faults_s,
    latch_open,
    short_reg,
    busy_reg,
    self_test_flag
  };

  wire logic [31:0] rd_data =
      sel_ctrl  ? {31'h00000000, track_en_reg} :
      sel_stat  ? status_word :
      sel_istat ? {29'h00000000, irq_stat_reg} :
      sel_imask ? {29'h00000000, irq_mask_reg} :
      sel_angle ? {16'h0000, angle_view} :
      sel_latch ? {16'h0000, latched_reg} :
                  32'h00000000;

  wire logic [tdc_pkg::IRQ_W-1:0] irq_events = {res_change, busy_fall, self_test_rise};
  wire logic [tdc_pkg::IRQ_W-1:0] irq_w1c =
    (wr_en & sel_istat) ? pwdata[tdc_pkg::IRQ_W-1:0] : '0;

  // A new event wins over a clear written in the same cycle.
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_prev_reg <= 1'b0;
      dn_prev_reg <= 1'b0;
      pend_up_reg <= 1'b0;
      pend_dn_reg <= 1'b0;
    end else begin
      up_prev_reg <= up_s;
      dn_prev_reg <= dn_s;
      pend_up_reg <= pend_up_next;
      pend_dn_reg <= pend_dn_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= tdc_pkg::BUSY_IDLE;
      cnt_reg       <= '0;
      busy_reg      <= 1'b0;
      busy_prev_reg <= 1'b0;
      dir_up_reg    <= 1'b0;
      open_at_start_reg <= 1'b1;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      busy_reg      <= busy_next;
      busy_prev_reg <= busy_reg;
      if (start) begin
        dir_up_reg        <= take_up;
        open_at_start_reg <= hold_n_s;
      end
    end
  end

  // The counter moves only after the data delay, well inside the busy pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_reg <= 16'h0000;
    end else if (delay_done) begin
      angle_reg <= angle_step;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_reg <= 1'b0;
    end else if (busy_fall) begin
      short_reg <= short_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_reg <= 16'h0000;
    end else if (latch_open) begin
      latched_reg <= angle_view;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_test_flag <= 1'b0;
    end else begin
      self_test_flag <= fault_any;
    end
  end

  // Each byte drives the shared bus only while its own enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_byte <= '0;
      lower_byte <= '0;
    end else begin
      upper_byte.data <= latched_reg[15:8];
      upper_byte.oe   <= ~ube_n_s;
      lower_byte.data <= latched_reg[7:0];
      lower_byte.oe   <= ~lbe_n_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_busy_pulse <= 1'b0;
    end else begin
      update_busy_pulse <= busy_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_en_reg <= tdc_pkg::CTRL_TRACK_RST;
      irq_mask_reg <= tdc_pkg::IRQ_MASK_RST;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        track_en_reg <= pwdata[tdc_pkg::CTRL_TRACK_BIT];
      end
      if (sel_imask) begin
        irq_mask_reg <= pwdata[tdc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // One wait state gives a registered read path at the cost of a cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~hit;
      if (acc_first) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

endmodule : tdc_core

`default_nettype wire

// ==== tdc_core_monitor.sv ====
// Concurrent checks on the converter control ports.
`timescale 1ns/1ps
`default_nettype none
module tdc_core_monitor (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                pready,
  input wire tdc_pkg::tdc_fault_s fault_in,
  input wire logic                hold_request_n,
  input wire logic                upper_byte_enable_n,
  input wire logic                lower_byte_enable_n,
  input wire logic                update_busy_pulse,
  input wire logic                self_test_flag,
  input wire tdc_pkg::tdc_byte_s  upper_byte,
  input wire tdc_pkg::tdc_byte_s  lower_byte
);
  logic [7:0] busy_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A counter is used because a repetition of 80 would be too slow to unroll.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 8'h00;
    end else begin
      busy_cnt <= update_busy_pulse ? busy_cnt + 8'h01 : 8'h00;
    end
  end
  property p_busy_width;
    $fell(update_busy_pulse) |-> busy_cnt == 8'(tdc_pkg::BUSY_CYC);
  endproperty
  a_busy_width: assert property (p_busy_width)
    else $error("busy pulse width wrong");
  property p_busy_max;
    busy_cnt <= 8'(tdc_pkg::BUSY_CYC);
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy pulse too long");
  property p_flag_set;
    (|fault_in) [*4] |-> self_test_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("self test flag not raised");
  property p_flag_clr;
    (fault_in == '0) [*4] |-> !self_test_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("self test flag not cleared");
  property p_tristate;
    (upper_byte_enable_n && lower_byte_enable_n) [*4] |-> !upper_byte.oe && !lower_byte.oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("angle lines driven while disabled");
  property p_upper_on;
    (!upper_byte_enable_n) [*4] |-> upper_byte.oe;
  endproperty
  a_upper_on: assert property (p_upper_on)
    else $error("upper byte not driven");
  property p_busy_lock;
    update_busy_pulse [*3] |-> $stable(upper_byte.data) && $stable(lower_byte.data);
  endproperty
  a_busy_lock: assert property (p_busy_lock)
    else $error("angle changed during busy");
  property p_hold_freeze;
    (!hold_request_n && !update_busy_pulse) [*8] |-> $stable({upper_byte.data, lower_byte.data});
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("angle changed during hold");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
endmodule : tdc_core_monitor
bind tdc_core tdc_core_monitor tdc_core_monitor_i (.pclk(pclk), .presetn(presetn),
  .pready(pready), .fault_in(fault_in), .hold_request_n(hold_request_n),
  .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
  .update_busy_pulse(update_busy_pulse), .self_test_flag(self_test_flag),
  .upper_byte(upper_byte), .lower_byte(lower_byte));
`default_nettype wire

// ==== tdc_host_model.sv ====
// Host that holds the converter and reads the angle bytes off a shared bus.
`timescale 1ns/1ps
`default_nettype none
module tdc_host_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               hold_cmd,
  input  wire logic [1:0]         read_cmd,
  input  wire tdc_pkg::tdc_byte_s upper_byte,
  input  wire tdc_pkg::tdc_byte_s lower_byte,
  output var  logic               hold_request_n,
  output var  logic               upper_byte_enable_n,
  output var  logic               lower_byte_enable_n,
  output var  logic [15:0]        bus_word
);
  // An undriven line shows the inverse so a stale byte never reads as valid.
  assign bus_word = {upper_byte.oe ? upper_byte.data : ~upper_byte.data,
                     lower_byte.oe ? lower_byte.data : ~lower_byte.data};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_request_n      <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
    end else begin
      hold_request_n      <= !hold_cmd;
      upper_byte_enable_n <= !read_cmd[1];
      lower_byte_enable_n <= !read_cmd[0];
    end
  end
endmodule : tdc_host_model
`default_nettype wire

// ==== tracking_converter_digital_control_test.sv ====
// Self-checking bench of the converter control.
`timescale 1ns/1ps
`default_nettype none
module tracking_converter_digital_control_test;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
  logic                vco_up, vco_down, short_word_select, hold_cmd, irq;
  logic                update_busy_pulse, self_test_flag;
  logic                hold_request_n, upper_byte_enable_n, lower_byte_enable_n;
  logic [1:0]          read_cmd;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic [15:0]         bus_word;
  tdc_pkg::tdc_fault_s fault_in;
  tdc_pkg::tdc_byte_s  upper_byte, lower_byte;
  int                  errors, n_tests, w;
  tdc_core tdc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .vco_up(vco_up), .vco_down(vco_down),
    .short_word_select(short_word_select), .hold_request_n(hold_request_n),
    .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
    .update_busy_pulse(update_busy_pulse), .self_test_flag(self_test_flag),
    .upper_byte(upper_byte), .lower_byte(lower_byte), .irq(irq));
  tdc_host_model tdc_host_model_i (.pclk(pclk), .presetn(presetn), .hold_cmd(hold_cmd),
    .read_cmd(read_cmd), .upper_byte(upper_byte), .lower_byte(lower_byte),
    .hold_request_n(hold_request_n), .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n), .bus_word(bus_word));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic results;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic step(input logic up);
    int n;
    @(posedge pclk);
    if (up) vco_up <= 1'b1;
    else vco_down <= 1'b1;
    n = 0;
    while (update_busy_pulse !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    vco_up <= 1'b0;
    vco_down <= 1'b0;
  endtask : step
  task automatic wait_idle;
    w = 0;
    while (update_busy_pulse === 1'b1 && w < 400) begin
      @(posedge pclk);
      w++;
    end
    repeat (4) @(posedge pclk);
  endtask : wait_idle
  task automatic t_faults;
    apb(1'b1, tdc_pkg::ADDR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      fault_in <= tdc_pkg::tdc_fault_s'(5'h01 << i);
      repeat (5) @(posedge pclk);
      chk("self_test_flag", 32'h1, {31'h0, self_test_flag});
      apb(1'b0, tdc_pkg::ADDR_STATUS, 32'h0);
      chk("status", (32'h10 << i) | 32'h1, rd & 32'h1F1);
      fault_in <= '0;
      repeat (5) @(posedge pclk);
      chk("self_test_flag", 32'h0, {31'h0, self_test_flag});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, tdc_pkg::ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
    end
    apb(1'b1, tdc_pkg::ADDR_IRQ_MASK, 32'h0);
    fault_in <= 5'h10;
    repeat (6) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    fault_in <= '0;
    apb(1'b0, 12'hFFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, slverr});
    chk("unmapped", 32'h0, rd);
  endtask : t_faults
  task automatic t_tristate;
    read_cmd <= 2'b00;
    repeat (6) @(posedge pclk);
    chk("oe", 32'h0, {30'h0, upper_byte.oe, lower_byte.oe});
    read_cmd <= 2'b10;
    repeat (6) @(posedge pclk);
    chk("oe", 32'h2, {30'h0, upper_byte.oe, lower_byte.oe});
    read_cmd <= 2'b11;
    repeat (6) @(posedge pclk);
    chk("oe", 32'h3, {30'h0, upper_byte.oe, lower_byte.oe});
  endtask : t_tristate
  task automatic t_step;
    step(1'b1);
    wait_idle;
    chk("busy width", 32'(tdc_pkg::BUSY_CYC), w);
    chk("bus word", {16'h0, tdc_pkg::STEP_LONG}, {16'h0, bus_word});
    apb(1'b0, tdc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("update irq", 32'h2, rd & 32'h2);
  endtask : t_step
  task automatic t_hold;
    hold_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    step(1'b0);
    wait_idle;
    chk("held word", {16'h0, tdc_pkg::STEP_LONG}, {16'h0, bus_word});
    apb(1'b0, tdc_pkg::ADDR_ANGLE, 32'h0);
    chk("counter", 32'h0, rd);
    hold_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("released word", 32'h0, {16'h0, bus_word});
    step(1'b1);
    hold_cmd <= 1'b1;
    wait_idle;
    chk("late hold word", {16'h0, tdc_pkg::STEP_LONG}, {16'h0, bus_word});
    hold_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : t_hold
  task automatic t_track;
    apb(1'b0, tdc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", {31'h0, tdc_pkg::CTRL_TRACK_RST}, rd);
    apb(1'b1, tdc_pkg::ADDR_CTRL, 32'h0);
    step(1'b1);
    chk("no update", 32'h0, {31'h0, update_busy_pulse});
    apb(1'b1, tdc_pkg::ADDR_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    wait_idle;
    chk("pending width", 32'(tdc_pkg::BUSY_CYC), w);
    apb(1'b0, tdc_pkg::ADDR_ANGLE, 32'h0);
    chk("pending step", 32'h2, rd);
  endtask : t_track
  task automatic t_short;
    short_word_select <= 1'b1;
    step(1'b1);
    apb(1'b0, tdc_pkg::ADDR_STATUS, 32'h0);
    chk("mode in busy", 32'h0, rd & 32'h4);
    wait_idle;
    apb(1'b0, tdc_pkg::ADDR_STATUS, 32'h0);
    chk("mode after busy", 32'h4, rd & 32'h4);
    apb(1'b0, tdc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("resolution irq", 32'h4, rd & 32'h4);
    chk("short word", 32'h0, {16'h0, bus_word});
    step(1'b1);
    wait_idle;
    chk("short step", {16'h0, tdc_pkg::STEP_SHORT}, {16'h0, bus_word});
  endtask : t_short
  initial begin
    {presetn, psel, penable, pwrite, vco_up, vco_down, short_word_select, hold_cmd} = '0;
    read_cmd = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0;
    fault_in = '0;
    errors = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_faults;
    t_tristate;
    t_step;
    t_hold;
    t_track;
    t_short;
    results;
  end
  // The span allows for every scenario with a wide margin.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    results;
  end
endmodule : tracking_converter_digital_control_test
`default_nettype wire
